// ### rtl/srps_pkg.sv
package srps_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_DOUT = 8'h08;
  localparam logic [7:0] OFF_IRQEN = 8'h0C;
  localparam logic [7:0] OFF_PIN_IN = 8'h10;
  localparam logic [7:0] OFF_EVENT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // pin index in every 4-bit pin vector
  localparam int PIN_ONE = 0;
  localparam int PIN_TWO = 1;
  localparam int PIN_FIVE = 2;
  localparam int PIN_TEN = 3;
  localparam int NPIN = 4;

  // control register layout
  localparam int CTRL_W = 9;
  localparam int C_FUNC_LSB = 0;
  localparam int C_LED_SEL = 2;
  localparam int C_TXD_SEL = 3;
  localparam int C_RXD_SEL = 4;
  localparam int C_CARD_MODE = 5;
  localparam int C_SUSPEND = 6;
  localparam int C_LED_ON = 7;
  localparam int C_CARD_ON = 8;

  // status register layout
  localparam int S_CHIP_RUN = 0;
  localparam int S_STRAP = 1;

  // irq enable register: edge select sits above the enables
  localparam int IRQ_RISE_LSB = 4;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [NPIN-1:0] DIR_RST = 4'h0;
  localparam logic [NPIN-1:0] DOUT_RST = 4'h0;
  localparam logic [NPIN-1:0] IRQEN_RST = 4'h0;
  localparam logic [NPIN-1:0] RISE_RST = 4'h0;

  // data-out pin function select
  typedef enum logic [1:0] {
    SRPS_FN_SPI = 2'b00,
    SRPS_FN_GPIO = 2'b01,
    SRPS_FN_I2C = 2'b10
  } srps_fn_t;

endpackage

// ### rtl/srps_pin_share.sv
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Function
// (RULE_01) in chip reset: data-out floats, pull-down on
// (RULE_02) reset release latches strap, drops pull-down
// (RULE_03) strap selects 30 or 60 MHz ROM
// (RULE_04) strap one: data-out floats in suspend
// (RULE_05) strap zero: data-out driven low in suspend
// (RULE_06) serial-in pull-down always on
// (RULE_07) I2C mode uses data-out pin as data
// (RULE_08) shared pins: input, edge interrupt or output
// (RULE_09) pin one: LED or UART transmit output
// (RULE_10) pin two: UART receive input when selected
// (RULE_11) card supply pin doubles as general pin
// (RULE_12) system holds chip reset low 1 us
// (RULE_13) strap held until next chip reset
module srps_pin_share (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic chip_reset_low,
  input wire logic general_pin_one_in,
  output logic general_pin_one_out,
  output logic general_pin_one_oe,
  input wire logic general_pin_two_in,
  output logic general_pin_two_out,
  output logic general_pin_two_oe,
  input wire logic general_pin_five_in,
  output logic general_pin_five_out,
  output logic general_pin_five_oe,
  output logic general_pin_five_pd,
  input wire logic general_pin_ten_in,
  output logic general_pin_ten_out,
  output logic general_pin_ten_oe,
  input wire logic rom_serial_in,
  output logic rom_serial_in_pd,
  input wire logic spi_data_out,
  input wire logic i2c_data_drive_low,
  input wire logic uart_txd,
  output logic rom_data,
  output logic i2c_data_in,
  output logic uart_rxd,
  output logic rom_speed_strap,
  output logic rom_fast_sel
);

  typedef struct packed {
    logic cr_s1;
    logic cr_s2;
    logic cr_prev;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_prev;
    logic rin_s1;
    logic rin_s2;
    logic strap;
    logic [8:0] ctrl;
    logic [3:0] dir;
    logic [3:0] dout;
    logic [3:0] irqen;
    logic [3:0] rise;
    logic [3:0] events;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic pin5_pd;
    logic rin_pd;
    logic rom_data;
    logic i2c_in;
    logic uart_rxd;
    logic fast_sel;
  } srps_state_t;

  localparam srps_state_t ST_RST = '{
    cr_s1: 1'b0, cr_s2: 1'b0, cr_prev: 1'b0,
    pin_s1: 4'h0, pin_s2: 4'h0, pin_prev: 4'h0,
    rin_s1: 1'b0, rin_s2: 1'b0, strap: 1'b0,
    ctrl: srps_pkg::CTRL_RST, dir: srps_pkg::DIR_RST, dout: srps_pkg::DOUT_RST,
    irqen: srps_pkg::IRQEN_RST, rise: srps_pkg::RISE_RST, events: 4'h0,
    ap_valid: 1'b0, ap_write: 1'b0, ap_addr: 8'h00,
    hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000,
    pin_out: 4'h0, pin_oe: 4'h0, pin5_pd: 1'b1, rin_pd: 1'b1,
    rom_data: 1'b0, i2c_in: 1'b0, uart_rxd: 1'b1, fast_sel: 1'b0
  };

  srps_state_t st_reg;
  srps_state_t st_next;

  // register read mux, unmapped offsets read zero
  function automatic logic [31:0] srps_read(input srps_state_t s);
    logic [31:0] v;
    case (s.ap_addr)
      srps_pkg::OFF_CTRL: v = {23'h000000, s.ctrl};
      srps_pkg::OFF_DIR: v = {28'h0000000, s.dir};
      srps_pkg::OFF_DOUT: v = {28'h0000000, s.dout};
      srps_pkg::OFF_IRQEN: v = {24'h000000, s.rise, s.irqen};
      srps_pkg::OFF_PIN_IN: v = {28'h0000000, s.pin_s2};
      srps_pkg::OFF_EVENT: v = {28'h0000000, s.events};
      srps_pkg::OFF_STATUS: v = {30'h00000000, s.strap, s.cr_s2};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  logic accept;
  logic [3:0] edges;
  logic [3:0] w1c;
  logic [3:0] gpio_oe;
  srps_pkg::srps_fn_t fn;

  // next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    accept = hsel && htrans[1] && hready;
    w1c = 4'h0;
    fn = srps_pkg::srps_fn_t'(st_reg.ctrl[srps_pkg::C_FUNC_LSB +: 2]);

    // two-flop synchronisers for pins; reset pulse far exceeds this delay
    st_next.cr_s1 = chip_reset_low;
    st_next.cr_s2 = st_reg.cr_s1; // RULE_12
    st_next.cr_prev = st_reg.cr_s2;
    st_next.pin_s1 = {general_pin_ten_in, general_pin_five_in, general_pin_two_in,
      general_pin_one_in};
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_prev = st_reg.pin_s2;
    st_next.rin_s1 = rom_serial_in;
    st_next.rin_s2 = st_reg.rin_s1;

    // strap latched only on chip reset release, held otherwise
    if (st_reg.cr_s2 && !st_reg.cr_prev) begin
      st_next.strap = st_reg.pin_s2[srps_pkg::PIN_FIVE]; // RULE_02 RULE_13
    end

    // edge detect on pins in interrupt mode
    edges = st_reg.irqen & ((st_reg.rise & st_reg.pin_s2 & ~st_reg.pin_prev) |
      (~st_reg.rise & ~st_reg.pin_s2 & st_reg.pin_prev)); // RULE_08

    // bus: writes finish with zero wait, reads take one wait state
    st_next.hresp = 1'b0;
    st_next.hreadyout = 1'b1;
    st_next.ap_valid = 1'b0;
    if (accept) begin
      st_next.ap_valid = 1'b1;
      st_next.ap_write = hwrite;
      st_next.ap_addr = haddr[7:0];
      st_next.hreadyout = hwrite;
    end
    if (st_reg.ap_valid && !st_reg.ap_write) begin
      st_next.hrdata = srps_read(st_reg);
    end
    if (st_reg.ap_valid && st_reg.ap_write) begin
      case (st_reg.ap_addr)
        srps_pkg::OFF_CTRL: st_next.ctrl = hwdata[srps_pkg::CTRL_W-1:0];
        srps_pkg::OFF_DIR: st_next.dir = hwdata[3:0];
        srps_pkg::OFF_DOUT: st_next.dout = hwdata[3:0];
        srps_pkg::OFF_IRQEN: begin
          st_next.irqen = hwdata[3:0];
          st_next.rise = hwdata[srps_pkg::IRQ_RISE_LSB +: 4];
        end
        srps_pkg::OFF_EVENT: w1c = hwdata[3:0];
        default: w1c = 4'h0;
      endcase
    end

    // sticky events, a new edge beats a clear
    st_next.events = (st_reg.events & ~w1c) | edges; // RULE_08

    // general-purpose defaults: output only when not in interrupt mode
    gpio_oe = st_reg.dir & ~st_reg.irqen; // RULE_08
    st_next.pin_oe = gpio_oe;
    st_next.pin_out = st_reg.dout;

    // pin one: transmit beats LED beats gpio
    if (st_reg.ctrl[srps_pkg::C_TXD_SEL]) begin
      st_next.pin_oe[srps_pkg::PIN_ONE] = 1'b1; // RULE_09
      st_next.pin_out[srps_pkg::PIN_ONE] = uart_txd;
    end else if (st_reg.ctrl[srps_pkg::C_LED_SEL]) begin
      st_next.pin_oe[srps_pkg::PIN_ONE] = 1'b1; // RULE_09
      st_next.pin_out[srps_pkg::PIN_ONE] = st_reg.ctrl[srps_pkg::C_LED_ON];
    end

    // pin two: receive routing, line idles high when not routed
    st_next.uart_rxd = 1'b1;
    if (st_reg.ctrl[srps_pkg::C_RXD_SEL]) begin
      st_next.pin_oe[srps_pkg::PIN_TWO] = 1'b0; // RULE_10
      st_next.uart_rxd = st_reg.pin_s2[srps_pkg::PIN_TWO];
    end

    // pin ten: card supply or gpio
    if (st_reg.ctrl[srps_pkg::C_CARD_MODE]) begin
      st_next.pin_oe[srps_pkg::PIN_TEN] = 1'b1; // RULE_11
      st_next.pin_out[srps_pkg::PIN_TEN] = st_reg.ctrl[srps_pkg::C_CARD_ON];
    end

    // pin five: serial data-out, gpio or open-drain I2C data
    case (fn)
      srps_pkg::SRPS_FN_SPI: begin
        st_next.pin_oe[srps_pkg::PIN_FIVE] = 1'b1;
        st_next.pin_out[srps_pkg::PIN_FIVE] = spi_data_out;
      end
      srps_pkg::SRPS_FN_I2C: begin
        st_next.pin_oe[srps_pkg::PIN_FIVE] = i2c_data_drive_low; // RULE_07
        st_next.pin_out[srps_pkg::PIN_FIVE] = 1'b0;
      end
      srps_pkg::SRPS_FN_GPIO: st_next.pin_oe[srps_pkg::PIN_FIVE] = gpio_oe[srps_pkg::PIN_FIVE];
      default: st_next.pin_oe[srps_pkg::PIN_FIVE] = 1'b0;
    endcase

    // suspend: float for fast strap, hold low for slow strap
    if (st_reg.ctrl[srps_pkg::C_SUSPEND]) begin
      st_next.pin_oe[srps_pkg::PIN_FIVE] = !st_reg.strap; // RULE_04 RULE_05
      st_next.pin_out[srps_pkg::PIN_FIVE] = 1'b0; // RULE_05
    end

    // chip reset: all pins float, config back to defaults
    st_next.pin5_pd = !st_reg.cr_s2; // RULE_01 RULE_02
    if (!st_reg.cr_s2) begin
      st_next.pin_oe = 4'h0; // RULE_01
      st_next.ctrl = srps_pkg::CTRL_RST;
      st_next.dir = srps_pkg::DIR_RST;
      st_next.dout = srps_pkg::DOUT_RST;
      st_next.irqen = srps_pkg::IRQEN_RST;
      st_next.rise = srps_pkg::RISE_RST;
      st_next.events = 4'h0;
    end

    // engine-facing signals
    st_next.rin_pd = 1'b1; // RULE_06
    st_next.rom_data = st_reg.rin_s2;
    st_next.i2c_in = st_reg.pin_s2[srps_pkg::PIN_FIVE]; // RULE_07
    st_next.fast_sel = st_reg.strap; // RULE_03
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state
  assign hreadyout = st_reg.hreadyout;
  assign hresp = st_reg.hresp;
  assign hrdata = st_reg.hrdata;
  assign general_pin_one_out = st_reg.pin_out[srps_pkg::PIN_ONE];
  assign general_pin_one_oe = st_reg.pin_oe[srps_pkg::PIN_ONE];
  assign general_pin_two_out = st_reg.pin_out[srps_pkg::PIN_TWO];
  assign general_pin_two_oe = st_reg.pin_oe[srps_pkg::PIN_TWO];
  assign general_pin_five_out = st_reg.pin_out[srps_pkg::PIN_FIVE];
  assign general_pin_five_oe = st_reg.pin_oe[srps_pkg::PIN_FIVE];
  assign general_pin_five_pd = st_reg.pin5_pd;
  assign general_pin_ten_out = st_reg.pin_out[srps_pkg::PIN_TEN];
  assign general_pin_ten_oe = st_reg.pin_oe[srps_pkg::PIN_TEN];
  assign rom_serial_in_pd = st_reg.rin_pd;
  assign rom_data = st_reg.rom_data;
  assign i2c_data_in = st_reg.i2c_in;
  assign uart_rxd = st_reg.uart_rxd;
  assign rom_speed_strap = st_reg.strap;
  assign rom_fast_sel = st_reg.fast_sel;

  // checks
  property p_reset_float;
    @(posedge mclk) disable iff (reset)
      !st_reg.cr_s2 |=> !general_pin_five_oe && general_pin_five_pd;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("pin driven in chip reset"); // RULE_01

  property p_strap_latch;
    @(posedge mclk) disable iff (reset)
      (st_reg.cr_s2 && !st_reg.cr_prev) |=>
        rom_speed_strap == $past(st_reg.pin_s2[srps_pkg::PIN_FIVE]) ##1 !general_pin_five_pd;
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("strap not latched"); // RULE_02

  property p_speed;
    @(posedge mclk) disable iff (reset)
      $changed(rom_speed_strap) |=> rom_fast_sel == $past(rom_speed_strap);
  endproperty
  a_speed: assert property (p_speed) else $error("speed select wrong"); // RULE_03

  property p_susp_fast;
    @(posedge mclk) disable iff (reset)
      st_reg.ctrl[srps_pkg::C_SUSPEND] && st_reg.strap && st_reg.cr_s2 |=> !general_pin_five_oe;
  endproperty
  a_susp_fast: assert property (p_susp_fast) else $error("pin driven in suspend"); // RULE_04

  property p_susp_slow;
    @(posedge mclk) disable iff (reset)
      st_reg.ctrl[srps_pkg::C_SUSPEND] && !st_reg.strap && st_reg.cr_s2 |=>
        general_pin_five_oe && !general_pin_five_out;
  endproperty
  a_susp_slow: assert property (p_susp_slow) else $error("pin not low in suspend"); // RULE_05

  property p_in_pd;
    @(posedge mclk) disable iff (reset) rom_serial_in_pd;
  endproperty
  a_in_pd: assert property (p_in_pd) else $error("serial-in pull-down off"); // RULE_06

  property p_i2c;
    @(posedge mclk) disable iff (reset)
      st_reg.cr_s2 && !st_reg.ctrl[srps_pkg::C_SUSPEND] && fn == srps_pkg::SRPS_FN_I2C |=>
        general_pin_five_oe == $past(i2c_data_drive_low) && !general_pin_five_out;
  endproperty
  a_i2c: assert property (p_i2c) else $error("I2C data drive wrong"); // RULE_07

  property p_edge_event;
    @(posedge mclk) disable iff (reset)
      st_reg.cr_s2 && edges[srps_pkg::PIN_TWO] |=> st_reg.events[srps_pkg::PIN_TWO];
  endproperty
  a_edge_event: assert property (p_edge_event) else $error("edge event lost"); // RULE_08

  property p_led;
    @(posedge mclk) disable iff (reset)
      st_reg.cr_s2 && st_reg.ctrl[srps_pkg::C_LED_SEL] && !st_reg.ctrl[srps_pkg::C_TXD_SEL] |=>
        general_pin_one_oe && general_pin_one_out == $past(st_reg.ctrl[srps_pkg::C_LED_ON]);
  endproperty
  a_led: assert property (p_led) else $error("LED output wrong"); // RULE_09

  property p_rxd;
    @(posedge mclk) disable iff (reset)
      st_reg.ctrl[srps_pkg::C_RXD_SEL] |=>
        uart_rxd == $past(st_reg.pin_s2[srps_pkg::PIN_TWO]) && !general_pin_two_oe;
  endproperty
  a_rxd: assert property (p_rxd) else $error("receive routing wrong"); // RULE_10

  property p_card;
    @(posedge mclk) disable iff (reset)
      st_reg.cr_s2 && !st_reg.ctrl[srps_pkg::C_CARD_MODE] |=>
        general_pin_ten_oe == $past(gpio_oe[srps_pkg::PIN_TEN]);
  endproperty
  a_card: assert property (p_card) else $error("card pin gpio wrong"); // RULE_11

  property p_strap_hold;
    @(posedge mclk) disable iff (reset)
      st_reg.cr_s2 && st_reg.cr_prev |=> $stable(st_reg.strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed"); // RULE_13

  property p_c_release;
    @(posedge mclk) disable iff (reset) st_reg.cr_s2 && !st_reg.cr_prev;
  endproperty
  c_release: cover property (p_c_release);

  property p_c_suspend;
    @(posedge mclk) disable iff (reset) st_reg.ctrl[srps_pkg::C_SUSPEND] && st_reg.strap;
  endproperty
  c_suspend: cover property (p_c_suspend);
  property p_c_event;
    @(posedge mclk) disable iff (reset) edges != 4'h0;
  endproperty
  c_event: cover property (p_c_event);

endmodule // srps_pin_share

// ### sim/srps_rom_model.sv
`timescale 1ns/100ps
// far side: serial rom with its optional strap resistor on the data-out pin
module srps_rom_model (
  input wire logic mclk,
  input wire logic strap_pullup,
  input wire logic rom_drive,
  input wire logic rom_level,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic dev_pd,
  input wire logic in_pd,
  output logic pin_level,
  output logic serial_level
);
  logic last_pin = 1'b0;
  logic last_serial = 1'b0;

  // a released line with no pull shows the inverse of its last driven level
  always @(posedge mclk) begin
    if (dev_oe) begin
      last_pin <= dev_out;
    end
    if (rom_drive) begin
      last_serial <= rom_level;
    end
  end

  // data-out pin: device drive wins, then the strap resistor, then the pull-down
  assign pin_level = dev_oe ? dev_out : (strap_pullup ? 1'b1 : (dev_pd ? 1'b0 : ~last_pin));
  // data-in pin: rom drives it, else the device pull-down holds it low
  assign serial_level = rom_drive ? rom_level : (in_pd ? 1'b0 : ~last_serial);
endmodule // srps_rom_model

// ### sim/test_srps_pin_share.sv
`timescale 1ns/100ps
module test_srps_pin_share;
  logic mclk, reset, hsel, hwrite, chip_reset_low, spi_data_out, i2c_data_drive_low, uart_txd;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic one_lvl, two_lvl, ten_lvl, strap_pullup, rom_drive, rom_level;
  logic hreadyout, hresp, one_out, one_oe, two_out, two_oe, five_out, five_oe, five_pd;
  logic [31:0] hrdata;
  logic ten_out, ten_oe, in_pd, rom_data, i2c_data_in, uart_rxd, rom_speed_strap, rom_fast_sel;
  logic p5_lvl, si_lvl;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  srps_pin_share dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chip_reset_low(chip_reset_low),
    .general_pin_one_in(one_oe ? one_out : one_lvl), .general_pin_one_out(one_out),
    .general_pin_one_oe(one_oe), .general_pin_two_in(two_oe ? two_out : two_lvl),
    .general_pin_two_out(two_out), .general_pin_two_oe(two_oe),
    .general_pin_five_in(p5_lvl), .general_pin_five_out(five_out),
    .general_pin_five_oe(five_oe), .general_pin_five_pd(five_pd),
    .general_pin_ten_in(ten_oe ? ten_out : ten_lvl), .general_pin_ten_out(ten_out),
    .general_pin_ten_oe(ten_oe), .rom_serial_in(si_lvl), .rom_serial_in_pd(in_pd),
    .spi_data_out(spi_data_out), .i2c_data_drive_low(i2c_data_drive_low),
    .uart_txd(uart_txd), .rom_data(rom_data), .i2c_data_in(i2c_data_in),
    .uart_rxd(uart_rxd), .rom_speed_strap(rom_speed_strap), .rom_fast_sel(rom_fast_sel));

  srps_rom_model rom (.mclk(mclk), .strap_pullup(strap_pullup), .rom_drive(rom_drive),
    .rom_level(rom_level), .dev_out(five_out), .dev_oe(five_oe), .dev_pd(five_pd),
    .in_pd(in_pd), .pin_level(p5_lvl), .serial_level(si_lvl));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // let n edges pass, then look at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  // one ahb-lite single transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
    hsel <= 1'b0;
  endtask

  // chip reset pulse, strap resistor fitted or not
  task automatic t_chip_reset(input logic strap);
    @(posedge mclk);
    chip_reset_low <= 1'b0;
    strap_pullup <= strap;
    spi_data_out <= 1'b0;
    settle(60);
    chk("pin5 oe in reset", 32'h0, five_oe);
    chk("pin5 pd in reset", 32'h1, five_pd);
    chk("serial in pd", 32'h1, in_pd);
    @(posedge mclk);
    chip_reset_low <= 1'b1;
    settle(6);
    chk("strap", strap, rom_speed_strap);
    chk("pin5 pd released", 32'h0, five_pd);
    chk("rom fast", strap, rom_fast_sel);
    chk("pin5 spi oe", 32'h1, five_oe);
    bus(1'b0, srps_pkg::OFF_STATUS, 32'h0);
    chk("status strap", strap, rd[srps_pkg::S_STRAP]);
    @(posedge mclk);
    spi_data_out <= 1'b1;
    strap_pullup <= ~strap;
    settle(4);
    chk("pin5 spi data", 32'h1, five_out);
    chk("strap held", strap, rom_speed_strap);
  endtask

  // suspend with the given strap
  task automatic t_suspend(input logic strap);
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h40);
    settle(3);
    chk("suspend oe", {31'h0, ~strap}, five_oe);
    if (!strap) begin
      chk("suspend level", 32'h0, five_out);
    end
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h0);
  endtask

  task automatic t_serial_in;
    @(posedge mclk);
    rom_drive <= 1'b1;
    rom_level <= 1'b1;
    settle(5);
    chk("rom data high", 32'h1, rom_data);
    @(posedge mclk);
    rom_drive <= 1'b0;
    settle(5);
    chk("rom data released", 32'h0, rom_data);
    chk("serial in pd", 32'h1, in_pd);
  endtask

  task automatic t_i2c;
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h2);
    @(posedge mclk);
    i2c_data_drive_low <= 1'b1;
    settle(4);
    chk("i2c low oe", 32'h1, five_oe);
    chk("i2c low out", 32'h0, five_out);
    chk("i2c in low", 32'h0, i2c_data_in);
    @(posedge mclk);
    i2c_data_drive_low <= 1'b0;
    strap_pullup <= 1'b1;
    settle(5);
    chk("i2c release", 32'h0, five_oe);
    chk("i2c in high", 32'h1, i2c_data_in);
  endtask

  // outputs, inputs, edge events, read-only and unmapped places
  task automatic t_gpio;
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h1);
    bus(1'b1, srps_pkg::OFF_DIR, 32'hF);
    bus(1'b1, srps_pkg::OFF_DOUT, 32'hA);
    settle(3);
    chk("outs", 32'hA, {ten_out, five_out, two_out, one_out});
    chk("oes", 32'hF, {ten_oe, five_oe, two_oe, one_oe});
    bus(1'b1, srps_pkg::OFF_DIR, 32'h0);
    @(posedge mclk);
    one_lvl <= 1'b1;
    two_lvl <= 1'b0;
    ten_lvl <= 1'b1;
    settle(4);
    bus(1'b1, srps_pkg::OFF_PIN_IN, 32'h0);
    bus(1'b0, srps_pkg::OFF_PIN_IN, 32'h0);
    chk("pin in", 32'hD, rd);
    bus(1'b1, srps_pkg::OFF_IRQEN, 32'h13);
    bus(1'b1, srps_pkg::OFF_EVENT, 32'hF);
    @(posedge mclk);
    one_lvl <= 1'b0;
    two_lvl <= 1'b1;
    settle(4);
    bus(1'b0, srps_pkg::OFF_EVENT, 32'h0);
    chk("wrong edges", 32'h0, rd);
    @(posedge mclk);
    one_lvl <= 1'b1;
    two_lvl <= 1'b0;
    settle(4);
    bus(1'b0, srps_pkg::OFF_EVENT, 32'h0);
    chk("events", 32'h3, rd);
    bus(1'b1, srps_pkg::OFF_EVENT, 32'h3);
    bus(1'b0, srps_pkg::OFF_EVENT, 32'h0);
    chk("events cleared", 32'h0, rd);
    bus(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, srps_pkg::OFF_IRQEN, 32'h0);
  endtask

  // pin one as lamp or transmit, pin two as receive
  task automatic t_uart_led;
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h84);
    settle(3);
    chk("led", 32'h3, {one_oe, one_out});
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h9C);
    @(posedge mclk);
    uart_txd <= 1'b0;
    two_lvl <= 1'b0;
    settle(4);
    chk("txd low", 32'h2, {one_oe, one_out});
    chk("rxd low", 32'h0, uart_rxd);
    @(posedge mclk);
    uart_txd <= 1'b1;
    two_lvl <= 1'b1;
    settle(4);
    chk("txd high", 32'h1, one_out);
    chk("rxd high", 32'h1, uart_rxd);
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h0);
    @(posedge mclk);
    two_lvl <= 1'b0;
    settle(4);
    chk("rxd unrouted", 32'h1, uart_rxd);
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h120);
    settle(3);
    chk("card on", 32'h3, {ten_oe, ten_out});
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h20);
    settle(3);
    chk("card off", 32'h2, {ten_oe, ten_out});
    bus(1'b1, srps_pkg::OFF_CTRL, 32'h0);
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    chip_reset_low = 1'b0;
    spi_data_out = 1'b0;
    i2c_data_drive_low = 1'b0;
    uart_txd = 1'b1;
    one_lvl = 1'b0;
    two_lvl = 1'b0;
    ten_lvl = 1'b0;
    strap_pullup = 1'b0;
    rom_drive = 1'b0;
    rom_level = 1'b0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_chip_reset(1'b1);
    t_suspend(1'b1);
    t_chip_reset(1'b0);
    t_suspend(1'b0);
    t_serial_in();
    t_i2c();
    t_gpio();
    t_uart_led();
    end_of_test();
  end
endmodule // test_srps_pin_share
